// ==== hw/swdt_defs.svh ====
// constants of the system watchdog timer: offsets, field positions, reset values, timing
// assumes inclusion by bare name from the watchdog design files
`ifndef SWDT_DEFS_SVH
`define SWDT_DEFS_SVH

`define SWDT_ADDR_CONTROL     8'hAA
`define SWDT_ADDR_STATUS      8'hAC
`define SWDT_ADDR_MASK        8'hAD

`define SWDT_CTL_ENABLE_BIT   7
`define SWDT_CTL_CLEAR_BIT    6
`define SWDT_CTL_SLEEP_BIT    4
`define SWDT_CTL_CAUSE_BIT    3
`define SWDT_CTL_PS_MSB       2
`define SWDT_CTL_PS_LSB       0

`define SWDT_OPT_OFF_BIT      7
`define SWDT_OPT_UNPROGRAMMED 8'hFF

`define SWDT_PS_RESET         3'h0
`define SWDT_SLEEP_RESET      1'h0
`define SWDT_CAUSE_RESET      1'h0
`define SWDT_STS_RESET        2'h0
`define SWDT_MASK_RESET       2'h0

`define SWDT_STS_TIMEOUT_BIT  0
`define SWDT_STS_LOCKED_BIT   1

`define SWDT_TIMEOUT_TICKS    64
`define SWDT_LRC_FREQ_HZ      10000
`define SWDT_CLK_PERIOD_NS    10
`define SWDT_RST_HOLD_NS      40
`define SWDT_RST_HOLD_CYC     (((`SWDT_RST_HOLD_NS)+(`SWDT_CLK_PERIOD_NS)-1)/(`SWDT_CLK_PERIOD_NS))

`endif

// ==== hw/swdt_pkg.sv ====
// types shared by the system watchdog timer files
// assumes nothing beyond a SystemVerilog compiler
package swdt_pkg;
    typedef enum logic {
        SWDT_RUN,
        SWDT_RST_HOLD
    } swdt_state_t;

    typedef logic [2:0] swdt_ps_t;
endpackage

// ==== hw/swdt_prescaler.sv ====
// prescaler for the low-speed rc tick of the system watchdog timer
// assumes src_tick is a one-cycle pulse synchronous to clk_sys
`timescale 1ns/10ps
module swdt_prescaler #(
    parameter int DIV_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n_sync,
    input  wire logic              clear,
    input  wire logic              run,
    input  wire logic              src_tick,
    input  wire swdt_pkg::swdt_ps_t sel,
    output logic                   div_tick
);
    if (DIV_W < 8)
    begin : g_width_check
        $error("swdt_prescaler: DIV_W must reach the largest division of 256");
    end

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] div_mask;
    logic             at_end;
    logic [DIV_W-1:0] next_cnt;

    // divisions 1,2,8,16,32,64,128,256 as terminal counts
    always_comb
    begin
        case (sel)
            3'h0:    div_mask = DIV_W'(8'h00);
            3'h1:    div_mask = DIV_W'(8'h01);
            3'h2:    div_mask = DIV_W'(8'h07);
            3'h3:    div_mask = DIV_W'(8'h0F);
            3'h4:    div_mask = DIV_W'(8'h1F);
            3'h5:    div_mask = DIV_W'(8'h3F);
            3'h6:    div_mask = DIV_W'(8'h7F);
            default: div_mask = DIV_W'(8'hFF);
        endcase
    end

    assign at_end   = (cnt >= div_mask);
    assign div_tick = run && src_tick && at_end;
    assign next_cnt = clear ? '0 :
                      (run && src_tick) ? (at_end ? '0 : cnt + DIV_W'(1)) : cnt;

    always_ff @(posedge clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            cnt <= '0;
        else
            cnt <= next_cnt;
    end
endmodule

// ==== hw/swdt_top.sv ====
// system watchdog timer: counter, prescaler, timed-access control register, reset-cause flag
// assumes inputs synchronous to clk_sys; lrc_clk is the slow rc oscillator sampled as a level
`timescale 1ns/10ps
`include "swdt_defs.svh"
module swdt_top #(
    parameter int CNT_W = 6,
    parameter int DIV_W = 8
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       sys_rst_req,
    input  wire logic       lrc_clk,
    input  wire logic       cpu_idle,
    input  wire logic       cpu_power_down,
    input  wire logic       timed_access,
    input  wire logic [7:0] boot_option_byte3,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            wdt_sys_reset,
    output logic            irq
);
    if ((2 ** CNT_W) != `SWDT_TIMEOUT_TICKS)
    begin : g_cnt_check
        $error("swdt_top: CNT_W must span exactly the time-out tick count");
    end

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(`SWDT_TIMEOUT_TICKS - 1);
    localparam logic [2:0]       HOLD_LAST = 3'(`SWDT_RST_HOLD_CYC - 1);

    // reset release
    logic rst_meta_b;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_n      <= rst_meta_b;
        end
    end

    // control and status state
    logic                 watchdog_enable;
    logic                 run_in_sleep;
    logic                 reset_cause_flag;
    swdt_pkg::swdt_ps_t   prescale_select;
    logic                 option_pending;
    logic [CNT_W-1:0]     watchdog_counter;
    logic [1:0]           irq_status;
    logic [1:0]           irq_mask;
    logic                 lrc_prev;
    logic                 sleep_prev;
    logic [2:0]           hold_cnt;
    swdt_pkg::swdt_state_t state;

    // register decode
    wire sel_ctl      = (reg_addr == `SWDT_ADDR_CONTROL);
    wire sel_sts      = (reg_addr == `SWDT_ADDR_STATUS);
    wire sel_msk      = (reg_addr == `SWDT_ADDR_MASK);
    wire ctl_wr_ok    = reg_wr && sel_ctl && timed_access;
    wire ctl_wr_lock  = reg_wr && sel_ctl && !timed_access;
    wire sts_wr       = reg_wr && sel_sts;
    wire msk_wr       = reg_wr && sel_msk;
    wire clear_req    = ctl_wr_ok && reg_wdata[`SWDT_CTL_CLEAR_BIT];

    // counting conditions
    wire asleep       = cpu_idle || cpu_power_down;
    wire sleep_edge   = asleep != sleep_prev;
    wire lrc_tick     = lrc_clk && !lrc_prev;
    wire running      = (state == swdt_pkg::SWDT_RUN);
    wire count_run    = running && watchdog_enable && (!asleep || run_in_sleep);
    // a system reset request restarts the count like any other reset
    wire cnt_clear    = clear_req || sleep_edge || !running || (sys_rst_req && running);
    wire div_tick;
    wire timeout      = div_tick && (watchdog_counter == CNT_LAST);
    wire soft_reset   = timeout || (sys_rst_req && running);
    wire option_en    = !boot_option_byte3[`SWDT_OPT_OFF_BIT];

    wire [7:0] ctl_view = {watchdog_enable, 1'b0, 1'b0, run_in_sleep,
                           reset_cause_flag, prescale_select};
    wire [7:0] next_rdata = !reg_rd ? 8'h00 :
                            sel_ctl ? ctl_view :
                            sel_sts ? {6'h00, irq_status} :
                            sel_msk ? {6'h00, irq_mask} : 8'h00;
    wire [1:0] sts_event;
    assign sts_event[`SWDT_STS_TIMEOUT_BIT] = timeout;
    assign sts_event[`SWDT_STS_LOCKED_BIT]  = ctl_wr_lock;
    wire [1:0] next_status = (irq_status & ~(sts_wr ? reg_wdata[1:0] : 2'h0)) | sts_event;

    swdt_prescaler #(
        .DIV_W      (DIV_W)
    ) u_prescaler (
        .clk_sys    (clk_sys),
        .rst_n_sync (rst_n),
        .clear      (cnt_clear),
        .run        (count_run),
        .src_tick   (lrc_tick),
        .sel        (prescale_select),
        .div_tick   (div_tick)
    );

    // counter: counts 64 divided ticks, cleared by software, sleep edges and reset hold
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            watchdog_counter <= '0;
        else if (cnt_clear)
            watchdog_counter <= '0;
        else if (div_tick)
            watchdog_counter <= watchdog_counter + CNT_W'(1);
    end

    // edge history of the slow clock and the sleep state
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lrc_prev   <= 1'b0;
            sleep_prev <= 1'b0;
        end
        else
        begin
            lrc_prev   <= lrc_clk;
            sleep_prev <= asleep;
        end
    end

    // reset pulse generator: no interrupt stage, straight to system reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state         <= swdt_pkg::SWDT_RUN;
            hold_cnt      <= 3'h0;
            wdt_sys_reset <= 1'b0;
        end
        else
        begin
            case (state)
                swdt_pkg::SWDT_RUN:
                begin
                    if (timeout)
                    begin
                        state         <= swdt_pkg::SWDT_RST_HOLD;
                        wdt_sys_reset <= 1'b1;
                        hold_cnt      <= 3'h0;
                    end
                end
                swdt_pkg::SWDT_RST_HOLD:
                begin
                    if (hold_cnt == HOLD_LAST)
                    begin
                        state         <= swdt_pkg::SWDT_RUN;
                        wdt_sys_reset <= 1'b0;
                    end
                    else
                        hold_cnt <= hold_cnt + 3'h1;
                end
                default:
                begin
                    state         <= swdt_pkg::SWDT_RUN;
                    wdt_sys_reset <= 1'b0;
                end
            endcase
        end
    end

    // enable: loaded from the option byte after power-on and after every other reset
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            option_pending  <= 1'b1;
            watchdog_enable <= 1'b0;
        end
        else
        begin
            option_pending <= 1'b0;
            if (option_pending || soft_reset)
                watchdog_enable <= option_en;
            else if (ctl_wr_ok)
                watchdog_enable <= reg_wdata[`SWDT_CTL_ENABLE_BIT];
        end
    end

    // power-on-only fields; a soft reset keeps them
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_in_sleep    <= `SWDT_SLEEP_RESET;
            prescale_select <= `SWDT_PS_RESET;
        end
        else if (ctl_wr_ok && !soft_reset)
        begin
            run_in_sleep    <= reg_wdata[`SWDT_CTL_SLEEP_BIT];
            prescale_select <= reg_wdata[`SWDT_CTL_PS_MSB:`SWDT_CTL_PS_LSB];
        end
    end

    // reset-cause flag: the hardware set wins over a software clear
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reset_cause_flag <= `SWDT_CAUSE_RESET;
        else if (timeout)
            reset_cause_flag <= 1'b1;
        else if (ctl_wr_ok)
            reset_cause_flag <= reg_wdata[`SWDT_CTL_CAUSE_BIT];
    end

    // sticky status, mask and read data
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_status <= `SWDT_STS_RESET;
            irq_mask   <= `SWDT_MASK_RESET;
            irq        <= 1'b0;
            reg_rdata  <= 8'h00;
        end
        else
        begin
            irq_status <= next_status;
            if (msk_wr)
                irq_mask <= reg_wdata[1:0];
            irq       <= |(next_status & (msk_wr ? reg_wdata[1:0] : irq_mask));
            reg_rdata <= next_rdata;
        end
    end

    // checks
    AST_TIMEOUT_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        timeout |=> wdt_sys_reset && state == swdt_pkg::SWDT_RST_HOLD)
        else $error("time-out did not raise the system reset");

    AST_RESET_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(wdt_sys_reset) |-> wdt_sys_reset [*4] ##1 !wdt_sys_reset)
        else $error("system reset pulse has the wrong length");

    AST_CLEAR_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clear_req |=> watchdog_counter == '0 && !timeout)
        else $error("clear write did not zero the counter");

    AST_CLEAR_READS_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && sel_ctl |=> !reg_rdata[`SWDT_CTL_CLEAR_BIT])
        else $error("clear bit read back as one");

    AST_DISABLED_HOLDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !watchdog_enable && !cnt_clear |=> $stable(watchdog_counter))
        else $error("counter moved while disabled");

    AST_TIMEOUT_AT_64: assert property (@(posedge clk_sys) disable iff (!rst_n)
        timeout |-> watchdog_counter == 6'h3F && div_tick)
        else $error("time-out away from the 64th tick");

    AST_CAUSE_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        timeout |=> reset_cause_flag ##1 (reset_cause_flag || $past(ctl_wr_ok)))
        else $error("reset-cause flag not set by time-out");

    AST_SLEEP_HALT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        asleep && !run_in_sleep |-> !div_tick)
        else $error("counter advanced in sleep with sleep-run off");

    AST_SOFT_KEEPS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        soft_reset |=> $stable(prescale_select) && $stable(run_in_sleep))
        else $error("soft reset changed power-on-only fields");

    AST_ENABLE_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        soft_reset |=> watchdog_enable == !$past(boot_option_byte3[`SWDT_OPT_OFF_BIT]))
        else $error("enable not reloaded from the option byte");

    AST_SLEEP_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sleep_edge |=> watchdog_counter == '0)
        else $error("sleep entry or exit did not clear the counter");

    AST_LOCKED_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_wr_lock && !soft_reset && !option_pending && !timeout |=>
            $stable(watchdog_enable) && $stable(prescale_select) && irq_status[1])
        else $error("control changed by a write outside the unlock window");
endmodule

// ==== sim/swdt_top_test.sv ====
// self-checking bench for the system watchdog timer top level
// assumes the design files under hw/ and the constants header on the include path
`timescale 1ns/10ps
`include "swdt_defs.svh"
module swdt_top_test;
    logic       clk_sys;
    logic       rst_b;
    logic       sys_rst_req;
    logic       lrc_clk;
    logic       cpu_idle;
    logic       cpu_power_down;
    logic       timed_access;
    logic [7:0] boot_option_byte3;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       wdt_sys_reset;
    logic       irq;
    int         n_mismatch;
    int         comparisons;
    int         rises;
    int         hi_len;

    swdt_top DUT (
        .clk_sys           (clk_sys),
        .rst_b             (rst_b),
        .sys_rst_req       (sys_rst_req),
        .lrc_clk           (lrc_clk),
        .cpu_idle          (cpu_idle),
        .cpu_power_down    (cpu_power_down),
        .timed_access      (timed_access),
        .boot_option_byte3 (boot_option_byte3),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_wr            (reg_wr),
        .reg_rd            (reg_rd),
        .reg_rdata         (reg_rdata),
        .wdt_sys_reset     (wdt_sys_reset),
        .irq               (irq)
    );

    initial
    begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        sys_rst_req = 1'b0;
        lrc_clk = 1'b0;
        cpu_idle = 1'b0;
        cpu_power_down = 1'b0;
        timed_access = 1'b0;
        boot_option_byte3 = 8'h7F;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        rises = 0;
        hi_len = 0;
    end

    always #5 clk_sys = ~clk_sys;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // every pulse is counted and its width judged when it ends
    always @(posedge clk_sys)
    begin
        if (wdt_sys_reset === 1'b1)
        begin
            if (hi_len == 0)
                rises++;
            hi_len++;
        end
        else
        begin
            if (hi_len != 0)
                check(8'(hi_len), 8'h04, "reset pulse width");
            hi_len = 0;
        end
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic por(input logic [7:0] opt);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        boot_option_byte3 <= opt;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic ta);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        timed_access <= ta;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        timed_access <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp, what);
    endtask

    // one rc tick is two system cycles, the shortest level the sampler accepts
    task automatic run(input int n, input int exp_rst, input string what);
        int base;
        base = rises;
        repeat (n)
        begin
            @(posedge clk_sys);
            lrc_clk <= 1'b1;
            @(posedge clk_sys);
            lrc_clk <= 1'b0;
        end
        repeat (8) @(posedge clk_sys);
        check(8'(rises - base), 8'(exp_rst), what);
    endtask

    task automatic t_clear_lock;
        wr(`SWDT_ADDR_CONTROL, 8'hC0, 1'b1);
        run(40, 0, "before clear");
        wr(`SWDT_ADDR_CONTROL, 8'hC0, 1'b1);
        run(40, 0, "clear restarts count");
        rd_chk(`SWDT_ADDR_CONTROL, 8'h80, "clear reads zero");
        wr(`SWDT_ADDR_CONTROL, 8'h00, 1'b0);
        rd_chk(`SWDT_ADDR_CONTROL, 8'h80, "locked write");
        rd_chk(`SWDT_ADDR_STATUS, 8'h02, "locked status");
        wr(`SWDT_ADDR_STATUS, 8'h02, 1'b0);
        wr(`SWDT_ADDR_CONTROL, 8'h00, 1'b1);
        run(100, 0, "disabled");
        rd_chk(`SWDT_ADDR_CONTROL, 8'h00, "disabled readback");
    endtask

    task automatic t_timeout_irq;
        wr(`SWDT_ADDR_MASK, 8'h01, 1'b0);
        wr(`SWDT_ADDR_CONTROL, 8'hC0, 1'b1);
        run(63, 0, "one tick short");
        run(1, 1, "time-out");
        rd_chk(`SWDT_ADDR_CONTROL, 8'h88, "flag after time-out");
        check({7'h00, irq}, 8'h01, "irq raised");
        wr(`SWDT_ADDR_STATUS, 8'h01, 1'b0);
        repeat (2) @(posedge clk_sys);
        check({7'h00, irq}, 8'h00, "irq cleared");
        wr(`SWDT_ADDR_CONTROL, 8'h80, 1'b1);
        rd_chk(`SWDT_ADDR_CONTROL, 8'h80, "flag cleared by software");
    endtask

    task automatic t_sleep;
        wr(`SWDT_ADDR_CONTROL, 8'hC0, 1'b1);
        @(posedge clk_sys);
        cpu_idle <= 1'b1;
        run(100, 0, "halted in idle");
        @(posedge clk_sys);
        cpu_idle <= 1'b0;
        wr(`SWDT_ADDR_CONTROL, 8'hD0, 1'b1);
        run(40, 0, "awake count");
        @(posedge clk_sys);
        cpu_power_down <= 1'b1;
        run(40, 0, "cleared on entry");
        @(posedge clk_sys);
        cpu_power_down <= 1'b0;
        run(40, 0, "cleared on wake");
        run(24, 1, "time-out after wake");
    endtask

    task automatic t_prescale;
        int divs[8] = '{1, 2, 8, 16, 32, 64, 128, 256};
        wr(`SWDT_ADDR_MASK, 8'h00, 1'b0);
        for (int ps = 0; ps < 8; ps++)
        begin
            wr(`SWDT_ADDR_CONTROL, 8'hC0 | 8'(ps), 1'b1);
            run(64 * divs[ps] - 1, 0, "prescaled short");
            run(1, 1, "prescaled time-out");
            rd_chk(`SWDT_ADDR_CONTROL, 8'h88 | 8'(ps), "prescale kept");
        end
        rd_chk(`SWDT_ADDR_STATUS, 8'h01, "status sticky");
        check({7'h00, irq}, 8'h00, "irq masked");
        wr(`SWDT_ADDR_MASK, 8'h01, 1'b0);
        repeat (2) @(posedge clk_sys);
        check({7'h00, irq}, 8'h01, "irq unmasked");
        wr(`SWDT_ADDR_STATUS, 8'h01, 1'b0);
    endtask

    task automatic t_resets;
        wr(`SWDT_ADDR_CONTROL, 8'h9F, 1'b1);
        @(posedge clk_sys);
        boot_option_byte3 <= 8'hFF;
        sys_rst_req <= 1'b1;
        @(posedge clk_sys);
        sys_rst_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd_chk(`SWDT_ADDR_CONTROL, 8'h1F, "soft reset keeps fields");
        run(100, 0, "off after soft reset");
        por(8'h7F);
        rd_chk(`SWDT_ADDR_CONTROL, 8'h80, "power-on clears");
    endtask

    initial
    begin
        por(8'h7F);
        rd_chk(`SWDT_ADDR_CONTROL, 8'h80, "control reset value");
        rd_chk(`SWDT_ADDR_STATUS, 8'h00, "status reset value");
        rd_chk(`SWDT_ADDR_MASK, 8'h00, "mask reset value");
        rd_chk(8'h00, 8'h00, "unmapped read");
        t_clear_lock();
        t_timeout_irq();
        t_sleep();
        t_prescale();
        t_resets();
        give_verdict();
    end

    // the whole run needs about 67k cycles; reaching 90k cycles means a hang
    initial
    begin
        #900_000;
        n_mismatch++;
        give_verdict();
    end
endmodule
